// *** inc/hqfa_pkg.sv ***
package hqfa_pkg;
	localparam int HQFA_LANES = 4;
	localparam int HQFA_OFS_W = 11;
	localparam int HQFA_ROW_W = 9;

	// Byte offsets of the host-visible registers
	localparam logic [3:0] HQFA_OFS_RX_CMD = 4'h2;
	localparam logic [3:0] HQFA_OFS_TX_PTR = 4'h4;
	localparam logic [3:0] HQFA_OFS_RX_PTR = 4'h6;
	localparam logic [3:0] HQFA_OFS_DATA_LO = 4'h8;
	localparam logic [3:0] HQFA_OFS_DATA_HI = 4'ha;

	// Field positions inside a 16-bit register
	localparam int HQFA_BIT_RELEASE = 0;
	localparam int HQFA_BIT_AUTOINC = 14;
	localparam int HQFA_OFS_HI_MSB = 10;

	// Reset values
	localparam logic HQFA_RST_RELEASE = 1'b0;
	localparam logic HQFA_RST_AUTOINC = 1'b0;
	localparam logic [HQFA_OFS_W-1:0] HQFA_RST_OFS = 11'h000;

	// Host access: dword select in addr[3:2], lanes chosen by be
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} hqfa_host_req_s;

	// Queue manager reports a completed release or enqueue
	typedef struct packed {
		logic done;
		logic [HQFA_OFS_W-1:0] next_ofs;
	} hqfa_reload_s;

	// Receive MAC byte write into the receive frame queue
	typedef struct packed {
		logic we;
		logic [HQFA_OFS_W-1:0] addr;
		logic [7:0] data;
	} hqfa_mac_wr_s;
endpackage : hqfa_pkg

// *** verilog/hqfa_byte_ram.sv ***
`timescale 1ns/1ps
module hqfa_byte_ram (
	input wire logic SYS_CLK,
	input wire logic wr_en,
	input wire logic [hqfa_pkg::HQFA_ROW_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [hqfa_pkg::HQFA_ROW_W-1:0] rd_addr,
	output logic [7:0] rd_data
);
	import hqfa_pkg::*;

	logic [7:0] mem_q [2**HQFA_ROW_W];

	always_ff @(posedge SYS_CLK) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	// Read data held until the next enabled read
	always_ff @(posedge SYS_CLK) begin
		if (rd_en) begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule : hqfa_byte_ram

// *** verilog/hqfa_queue_access.sv ***
`timescale 1ns/1ps
// Function
// - Writing one to the release bit frees the current receive frame's buffer.
// - Release bit reads one until memory is freed, then clears itself.
// - Transmit auto-increment advances transmit offset after each data window write.
// - Transmit advance is one, two or four by access size.
// - Bit 14 of transmit pointer register, reset zero, enables transmit auto-increment.
// - Without auto-increment the transmit offset changes only on explicit writes and enqueue reloads.
// - Bits 10..0 of transmit pointer hold byte offset of next window access.
// - Transmit enqueue reloads transmit offset with next free frame location.
// - Receive auto-increment advances receive offset after each data window read.
// - Receive advance is one, two or four by access size.
// - Bit 14 of receive pointer register, reset zero, enables receive auto-increment.
// - Without auto-increment the receive offset changes only on explicit writes and release reloads.
// - Bits 10..0 of receive pointer, reset zero, give next window read offset.
// - Receive release reloads receive offset with next available frame location.
// - Low window reads receive queue, writes transmit queue, at the pointers.
// - Window is one-way buffers: transmit for writes, receive for reads.
// - Window accesses work at even, odd or dword-aligned pointers.
// - Byte, word and dword window accesses mix freely, each advancing by size.
// - Low and high windows sit in consecutive words, one dword on 32 bits.
// - High window behaves as the low window, starting at the same pointer byte.
module hqfa_queue_access (
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire hqfa_pkg::hqfa_host_req_s HOST_REQ,
	output logic HOST_WR_ACK,
	output logic HOST_RD_VALID,
	output logic [31:0] HOST_RDATA,
	output logic RX_RELEASE_REQ,
	input wire hqfa_pkg::hqfa_reload_s RX_RELOAD,
	input wire hqfa_pkg::hqfa_reload_s TX_RELOAD,
	input wire hqfa_pkg::hqfa_mac_wr_s MAC_RX_WR,
	input wire logic [hqfa_pkg::HQFA_OFS_W-1:0] MAC_TX_ADDR,
	output logic [7:0] MAC_TX_DATA
);
	import hqfa_pkg::*;

	function automatic logic [2:0] lane_count(input logic [3:0] be);
		lane_count = 3'({2'b00, be[0]} + {2'b00, be[1]} + {2'b00, be[2]} + {2'b00, be[3]});
	endfunction : lane_count

	function automatic logic [1:0] first_lane(input logic [3:0] be);
		if (be[0]) begin
			first_lane = 2'h0;
		end else if (be[1]) begin
			first_lane = 2'h1;
		end else if (be[2]) begin
			first_lane = 2'h2;
		end else begin
			first_lane = 2'h3;
		end
	endfunction : first_lane

	logic req_wr;
	logic req_rd;
	logic [1:0] req_dw;
	logic [2:0] req_cnt;
	logic [1:0] req_first;
	logic hit_rx_cmd;
	logic hit_tx_ptr;
	logic hit_rx_ptr;
	logic hit_window;
	logic win_wr;
	logic win_rd;
	logic [1:0] ln_cmd;
	logic [1:0] ln_txp;
	logic [1:0] ln_rxp;
	logic rel_set;
	logic txp_wr_lo;
	logic txp_wr_hi;
	logic rxp_wr_lo;
	logic rxp_wr_hi;
	logic [15:0] txp_wval;
	logic [15:0] rxp_wval;

	logic rel_q;
	logic tx_ai_q;
	logic rx_ai_q;
	logic [HQFA_OFS_W-1:0] tx_ofs_q;
	logic [HQFA_OFS_W-1:0] rx_ofs_q;

	logic [7:0] tx_rd [HQFA_LANES];
	logic [7:0] rx_rd [HQFA_LANES];
	logic [1:0] mac_lane_q;

	logic rd1_q;
	logic win1_q;
	logic [2:0] cnt1_q;
	logic [1:0] first1_q;
	logic [1:0] ptr1_q;
	logic [31:0] regval_q;
	logic [31:0] regval_d;
	logic [31:0] win_data;
	logic wack_q;
	logic rvalid_q;
	logic [31:0] rdata_q;

	// Both strobes at once is refused outright
	assign req_wr = HOST_REQ.wr & ~HOST_REQ.rd;
	assign req_rd = HOST_REQ.rd & ~HOST_REQ.wr;
	assign req_dw = HOST_REQ.addr[3:2];
	assign req_cnt = lane_count(HOST_REQ.be);
	assign req_first = first_lane(HOST_REQ.be);

	assign ln_cmd = HQFA_OFS_RX_CMD[1:0];
	assign ln_txp = HQFA_OFS_TX_PTR[1:0];
	assign ln_rxp = HQFA_OFS_RX_PTR[1:0];
	assign hit_rx_cmd = (req_dw == HQFA_OFS_RX_CMD[3:2]);
	assign hit_tx_ptr = (req_dw == HQFA_OFS_TX_PTR[3:2]);
	assign hit_rx_ptr = (req_dw == HQFA_OFS_RX_PTR[3:2]);
	// Low and high windows share one dword
	assign hit_window = (req_dw == HQFA_OFS_DATA_LO[3:2]) && (HQFA_OFS_DATA_HI[3:2] == req_dw);
	assign win_wr = req_wr & hit_window & (req_cnt != 3'h0);
	assign win_rd = req_rd & hit_window & (req_cnt != 3'h0);

	// Only a one in the release bit starts a release
	assign rel_set = req_wr & hit_rx_cmd & HOST_REQ.be[ln_cmd]
		& HOST_REQ.wdata[{ln_cmd, 3'h0} + HQFA_BIT_RELEASE];

	assign txp_wval = HOST_REQ.wdata[{ln_txp, 3'h0} +: 16];
	assign rxp_wval = HOST_REQ.wdata[{ln_rxp, 3'h0} +: 16];
	assign txp_wr_lo = req_wr & hit_tx_ptr & HOST_REQ.be[ln_txp];
	assign txp_wr_hi = req_wr & hit_tx_ptr & HOST_REQ.be[ln_txp + 2'h1];
	assign rxp_wr_lo = req_wr & hit_rx_ptr & HOST_REQ.be[ln_rxp];
	assign rxp_wr_hi = req_wr & hit_rx_ptr & HOST_REQ.be[ln_rxp + 2'h1];

	// A new request wins over a completion in the same cycle
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			rel_q <= HQFA_RST_RELEASE;
		end else if (rel_set) begin
			rel_q <= 1'b1;
		end else if (RX_RELOAD.done) begin
			rel_q <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			tx_ai_q <= HQFA_RST_AUTOINC;
		end else if (txp_wr_hi) begin
			tx_ai_q <= txp_wval[HQFA_BIT_AUTOINC];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			rx_ai_q <= HQFA_RST_AUTOINC;
		end else if (rxp_wr_hi) begin
			rx_ai_q <= rxp_wval[HQFA_BIT_AUTOINC];
		end
	end

	// Host write beats reload, reload beats auto-increment
	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			tx_ofs_q <= HQFA_RST_OFS;
		end else if (txp_wr_lo || txp_wr_hi) begin
			if (txp_wr_lo) begin
				tx_ofs_q[7:0] <= txp_wval[7:0];
			end
			if (txp_wr_hi) begin
				tx_ofs_q[HQFA_OFS_HI_MSB:8] <= txp_wval[HQFA_OFS_HI_MSB:8];
			end
		end else if (TX_RELOAD.done) begin
			tx_ofs_q <= TX_RELOAD.next_ofs;
		end else if (win_wr && tx_ai_q) begin
			tx_ofs_q <= tx_ofs_q + {8'h00, req_cnt};
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			rx_ofs_q <= HQFA_RST_OFS;
		end else if (rxp_wr_lo || rxp_wr_hi) begin
			if (rxp_wr_lo) begin
				rx_ofs_q[7:0] <= rxp_wval[7:0];
			end
			if (rxp_wr_hi) begin
				rx_ofs_q[HQFA_OFS_HI_MSB:8] <= rxp_wval[HQFA_OFS_HI_MSB:8];
			end
		end else if (RX_RELOAD.done) begin
			rx_ofs_q <= RX_RELOAD.next_ofs;
		end else if (win_rd && rx_ai_q) begin
			rx_ofs_q <= rx_ofs_q + {8'h00, req_cnt};
		end
	end

	// Four byte banks let any alignment move up to four bytes at once
	for (genvar b = 0; b < HQFA_LANES; b++) begin : g_bank
		logic [1:0] tx_k;
		logic [1:0] rx_k;
		logic tx_act;
		logic rx_act;
		logic [HQFA_OFS_W-1:0] tx_byte;
		logic [HQFA_OFS_W-1:0] rx_byte;
		logic [1:0] tx_src;

		assign tx_k = 2'(b) - tx_ofs_q[1:0];
		assign rx_k = 2'(b) - rx_ofs_q[1:0];
		assign tx_act = ({1'b0, tx_k} < req_cnt);
		assign rx_act = ({1'b0, rx_k} < req_cnt);
		assign tx_byte = tx_ofs_q + {9'h000, tx_k};
		assign rx_byte = rx_ofs_q + {9'h000, rx_k};
		assign tx_src = req_first + tx_k;

		hqfa_byte_ram u_tx_ram (
			.SYS_CLK(SYS_CLK),
			.wr_en(win_wr & tx_act),
			.wr_addr(tx_byte[HQFA_OFS_W-1:2]),
			.wr_data(HOST_REQ.wdata[{tx_src, 3'h0} +: 8]),
			.rd_en(1'b1),
			.rd_addr(MAC_TX_ADDR[HQFA_OFS_W-1:2]),
			.rd_data(tx_rd[b])
		);

		hqfa_byte_ram u_rx_ram (
			.SYS_CLK(SYS_CLK),
			.wr_en(MAC_RX_WR.we && (MAC_RX_WR.addr[1:0] == 2'(b))),
			.wr_addr(MAC_RX_WR.addr[HQFA_OFS_W-1:2]),
			.wr_data(MAC_RX_WR.data),
			.rd_en(win_rd & rx_act),
			.rd_addr(rx_byte[HQFA_OFS_W-1:2]),
			.rd_data(rx_rd[b])
		);
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			mac_lane_q <= 2'h0;
		end else begin
			mac_lane_q <= MAC_TX_ADDR[1:0];
		end
	end

	assign MAC_TX_DATA = tx_rd[mac_lane_q];

	// Register image; reserved bits and the unmapped dword read zero
	always_comb begin
		regval_d = 32'h0000_0000;
		if (hit_rx_cmd) begin
			regval_d[{ln_cmd, 3'h0} + HQFA_BIT_RELEASE] = rel_q;
		end
		if (hit_tx_ptr) begin
			regval_d[{ln_txp, 3'h0} + HQFA_BIT_AUTOINC] = tx_ai_q;
			regval_d[{ln_txp, 3'h0} +: HQFA_OFS_W] = tx_ofs_q;
		end
		if (hit_rx_ptr) begin
			regval_d[{ln_rxp, 3'h0} + HQFA_BIT_AUTOINC] = rx_ai_q;
			regval_d[{ln_rxp, 3'h0} +: HQFA_OFS_W] = rx_ofs_q;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			rd1_q <= 1'b0;
			win1_q <= 1'b0;
			cnt1_q <= 3'h0;
			first1_q <= 2'h0;
			ptr1_q <= 2'h0;
			regval_q <= 32'h0000_0000;
		end else begin
			rd1_q <= req_rd;
			win1_q <= win_rd;
			cnt1_q <= req_cnt;
			first1_q <= req_first;
			ptr1_q <= rx_ofs_q[1:0];
			regval_q <= regval_d;
		end
	end

	// Host lane j carries queue byte ptr + (j - first lane)
	always_comb begin
		logic [1:0] k;
		logic [1:0] bank;
		k = 2'h0;
		bank = 2'h0;
		win_data = 32'h0000_0000;
		for (int j = 0; j < HQFA_LANES; j++) begin
			k = 2'(j) - first1_q;
			bank = ptr1_q + k;
			if ((2'(j) >= first1_q) && ({1'b0, k} < cnt1_q)) begin
				win_data[j*8 +: 8] = rx_rd[bank];
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			rdata_q <= 32'h0000_0000;
			rvalid_q <= 1'b0;
			wack_q <= 1'b0;
		end else begin
			rvalid_q <= rd1_q;
			wack_q <= req_wr;
			if (rd1_q) begin
				rdata_q <= win1_q ? win_data : regval_q;
			end
		end
	end

	assign HOST_WR_ACK = wack_q;
	assign HOST_RD_VALID = rvalid_q;
	assign HOST_RDATA = rdata_q;
	assign RX_RELEASE_REQ = rel_q;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);

	a_release_set_seen: assert property (rel_set |=> RX_RELEASE_REQ)
		else $error("release request not raised after host write of one");
	a_release_holds_busy: assert property (RX_RELEASE_REQ && !RX_RELOAD.done |=> RX_RELEASE_REQ)
		else $error("release bit cleared before memory was freed");
	a_release_self_clear: assert property (RX_RELEASE_REQ && RX_RELOAD.done && !rel_set |=> !RX_RELEASE_REQ)
		else $error("release bit did not clear after memory freed");
	a_tx_reload_next: assert property (TX_RELOAD.done && !txp_wr_lo && !txp_wr_hi
		|=> tx_ofs_q == $past(TX_RELOAD.next_ofs))
		else $error("transmit offset not reloaded after enqueue");
	a_rx_reload_next: assert property (RX_RELOAD.done && !rxp_wr_lo && !rxp_wr_hi
		|=> rx_ofs_q == $past(RX_RELOAD.next_ofs))
		else $error("receive offset not reloaded after release");
	a_tx_advance_size: assert property (win_wr && tx_ai_q && !TX_RELOAD.done
		|=> tx_ofs_q == $past(tx_ofs_q) + 11'($past(lane_count(HOST_REQ.be))))
		else $error("transmit offset advance differs from access size");
	a_rx_advance_size: assert property (win_rd && rx_ai_q && !RX_RELOAD.done
		|=> rx_ofs_q == $past(rx_ofs_q) + 11'($past(lane_count(HOST_REQ.be))))
		else $error("receive offset advance differs from access size");
	a_tx_manual_hold: assert property (!tx_ai_q && !txp_wr_lo && !txp_wr_hi && !TX_RELOAD.done
		|=> $stable(tx_ofs_q))
		else $error("transmit offset moved without a write");
	a_rx_manual_hold: assert property (!rx_ai_q && !rxp_wr_lo && !rxp_wr_hi && !RX_RELOAD.done
		|=> $stable(rx_ofs_q))
		else $error("receive offset moved without a write");
	// Reads may follow each other every cycle, so no idle valid is demanded
	a_read_two_cycles: assert property (req_rd |-> ##2 HOST_RD_VALID)
		else $error("read data not returned two cycles after request");
	a_read_valid_source: assert property (HOST_RD_VALID |-> $past(req_rd, 2))
		else $error("read data returned without a read request");
	a_write_ack_next: assert property (req_wr |=> HOST_WR_ACK)
		else $error("write not acknowledged one cycle after request");
	a_ptr_reserved_zero: assert property (req_rd && hit_rx_ptr && !hit_window
		|-> ##2 HOST_RDATA[{ln_rxp, 3'h0} + 15] == 1'b0 && HOST_RDATA[{ln_txp, 3'h0} + 15] == 1'b0)
		else $error("reserved pointer bit read as one");
endmodule : hqfa_queue_access

// *** tb/hqfa_qm_model.sv ***
`timescale 1ns/1ps
module hqfa_qm_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic rel_req,
	output hqfa_pkg::hqfa_reload_s rx_reload,
	output hqfa_pkg::hqfa_reload_s tx_reload,
	output hqfa_pkg::hqfa_mac_wr_s mac_wr,
	output logic [10:0] tx_addr,
	input wire logic [7:0] tx_data
);
	import hqfa_pkg::*;
	int rel_delay = 3;
	int cnt = 0;
	logic busy = 1'b0;
	logic [10:0] rx_next = 11'h100;
	logic [10:0] tx_next = 11'h200;
	initial begin
		rx_reload = '0;
		tx_reload = '0;
		mac_wr = '0;
		tx_addr = '0;
	end
	// Offset is junk outside done, so a design that ignores done goes wrong
	always @(posedge clk) begin
		if (!rst_b || busy || !rel_req) begin
			rx_reload <= '{1'b0, ~rx_reload.next_ofs};
			cnt <= 0;
			busy <= busy && rel_req && rst_b;
		end else if (cnt == rel_delay) begin
			rx_reload <= '{1'b1, rx_next};
			busy <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
	task tx_enqueue();
		@(posedge clk);
		tx_reload <= '{1'b1, tx_next};
		@(posedge clk);
		tx_reload <= '{1'b0, ~tx_next};
	endtask : tx_enqueue
	task mac_write(input logic [10:0] a, input logic [7:0] d);
		@(posedge clk);
		mac_wr <= '{1'b1, a, d};
		@(posedge clk);
		mac_wr <= '{1'b0, ~a, ~d};
	endtask : mac_write
	task tx_peek(input logic [10:0] a, output logic [7:0] d);
		@(posedge clk);
		tx_addr <= a;
		@(posedge clk);
		// Sample away from the edge that reloads the read port
		@(negedge clk);
		d = tx_data;
	endtask : tx_peek
endmodule : hqfa_qm_model

// *** tb/hqfa_testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: %h, expected %h", $time, a, b); end end
module testbench;
	import hqfa_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	hqfa_host_req_s host_req = '0;
	logic wr_ack, rd_valid, rel_req;
	logic [31:0] rdata, got_e;
	hqfa_reload_s rx_reload, tx_reload;
	hqfa_mac_wr_s mac_wr;
	logic [10:0] tx_addr;
	logic [7:0] tx_data, b;
	logic [31:0] exp_q[$];
	logic [7:0] exp_tx[2048];
	logic [7:0] exp_rx[2048];
	logic [3:0] be_tbl[8] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'h6, 4'hf};
	logic [10:0] txp = '0, rxp = '0;
	logic txai = 1'b0, rxai = 1'b0;
	logic wr_due = 1'b0;
	int seed = 32'h5dcb;
	int fail_count = 0, comparisons = 0, cycles = 0, n;

	always #12.5 sys_clk = ~sys_clk;

	hqfa_queue_access uut (.SYS_CLK(sys_clk), .RST_B(rst_b), .HOST_REQ(host_req), .HOST_WR_ACK(wr_ack),
		.HOST_RD_VALID(rd_valid), .HOST_RDATA(rdata), .RX_RELEASE_REQ(rel_req), .RX_RELOAD(rx_reload),
		.TX_RELOAD(tx_reload), .MAC_RX_WR(mac_wr), .MAC_TX_ADDR(tx_addr), .MAC_TX_DATA(tx_data));
	hqfa_qm_model qm (.clk(sys_clk), .rst_b(rst_b), .rel_req(rel_req), .rx_reload(rx_reload),
		.tx_reload(tx_reload), .mac_wr(mac_wr), .tx_addr(tx_addr), .tx_data(tx_data));

	function automatic logic [31:0] ptrs();
		return {1'b0, rxai, 3'h0, rxp, 1'b0, txai, 3'h0, txp};
	endfunction : ptrs

	task automatic acc(input logic w, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d,
		input logic [31:0] e);
		if (!w) exp_q.push_back(e);
		host_req <= '{w, !w, a, be, d};
		@(posedge sys_clk);
		host_req.wr <= 1'b0;
		host_req.rd <= 1'b0;
		@(posedge sys_clk);
	endtask : acc

	task automatic set_tx(input logic ai, input logic [10:0] p);
		txai = ai;
		txp = p;
		acc(1'b1, 4'h4, 4'h3, ptrs() & 32'h0000ffff, '0);
	endtask : set_tx

	task automatic set_rx(input logic ai, input logic [10:0] p);
		rxai = ai;
		rxp = p;
		acc(1'b1, 4'h4, 4'hc, ptrs() & 32'hffff0000, '0);
	endtask : set_rx

	task automatic wwin(input logic [3:0] be, input logic [31:0] d);
		int k = 0;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				exp_tx[txp + k] = d[8*i +: 8];
				k++;
			end
		end
		acc(1'b1, 4'h8, be, d, '0);
		if (txai) txp += 11'(k);
	endtask : wwin

	task automatic rwin(input logic [3:0] a, input logic [3:0] be);
		int k = 0;
		logic [31:0] e = '0;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				e[8*i +: 8] = exp_rx[rxp + k];
				k++;
			end
		end
		acc(1'b0, a, be, '0, e);
		if (rxai) rxp += 11'(k);
	endtask : rwin

	task conclude();
		$display("mismatches %0d, comparisons %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude

	always @(negedge sys_clk) begin
		if (wr_ack !== 1'b0 || wr_due) begin
			`CHK(wr_ack, wr_due)
		end
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK(1'b1, 1'b0)
			end else begin
				got_e = exp_q.pop_front();
				`CHK(rdata, got_e)
			end
		end
	end

	// Whole run needs well under a thousand cycles
	always @(posedge sys_clk) begin
		wr_due <= host_req.wr & ~host_req.rd;
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		acc(1'b0, 4'h0, 4'hf, '0, '0);
		acc(1'b0, 4'h4, 4'hf, '0, '0);
		acc(1'b1, 4'h4, 4'hf, '1, '0);
		acc(1'b0, 4'h4, 4'hf, '0, 32'h47ff47ff);
		acc(1'b0, 4'hc, 4'hf, '0, '0);
		rxai = 1'b1;
		rxp = 11'h7ff;
		set_tx(1'b1, 11'h005);
		repeat (12) wwin(be_tbl[$random(seed) & 7], $random(seed));
		acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		set_tx(1'b0, 11'h010);
		wwin(4'hf, $random(seed));
		wwin(4'h6, $random(seed));
		acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		for (int a = 0; a < 64; a++) begin
			qm.tx_peek(11'(a), b);
			if (!$isunknown(exp_tx[a])) `CHK(b, exp_tx[a])
		end
		for (int a = 0; a < 64; a++) begin
			exp_rx[a] = 8'($random(seed));
			qm.mac_write(11'(a), exp_rx[a]);
		end
		set_rx(1'b1, 11'h003);
		repeat (10) rwin(4'h8, be_tbl[$random(seed) & 7]);
		rwin(4'ha, 4'hc);
		acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		set_rx(1'b0, 11'h002);
		rwin(4'h8, 4'hf);
		rwin(4'h8, 4'h3);
		acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		acc(1'b1, 4'h0, 4'h4, '0, '0);
		`CHK(rel_req, 1'b0)
		// Prompt and slow release by the queue manager
		for (int d = 0; d < 8; d += 7) begin
			qm.rel_delay = d;
			qm.rx_next = 11'h100 + 11'(d);
			set_rx(1'b1, 11'h020);
			acc(1'b1, 4'h0, 4'h4, 32'h00010000, '0);
			`CHK(rel_req, 1'b1)
			if (d > 0) acc(1'b0, 4'h0, 4'h4, '0, 32'h00010000);
			n = 0;
			while (rel_req === 1'b1 && n < 40) begin
				@(negedge sys_clk);
				n++;
			end
			`CHK(rel_req, 1'b0)
			@(posedge sys_clk);
			rxp = qm.rx_next;
			acc(1'b0, 4'h0, 4'hf, '0, '0);
			acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		end
		qm.tx_next = 11'h2a5;
		qm.tx_enqueue();
		txp = 11'h2a5;
		acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		// Both strobes at once must be ignored
		host_req <= '{1'b1, 1'b1, 4'h4, 4'hf, '1};
		@(posedge sys_clk);
		host_req.wr <= 1'b0;
		host_req.rd <= 1'b0;
		@(posedge sys_clk);
		acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		// Reset in mid-run returns both pointer registers to zero
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		txai = 1'b0;
		rxai = 1'b0;
		txp = '0;
		rxp = '0;
		acc(1'b0, 4'h4, 4'hf, '0, ptrs());
		repeat (4) @(posedge sys_clk);
		`CHK(exp_q.size(), 0)
		conclude();
	end
endmodule : testbench
